// ==== aca_params.svh ====
// How it works
// - Reading status clears the interrupt-pending flag in bit 7.
// - After a status read, a new carrier or set-ready change interrupts again.
// - Status bit 3 shows receive data register full.
// - Status bits 0-2 show parity, framing, overrun; valid while receive full.
// - Status bit 4 shows transmit data register empty while clear-to-send is true.
// - A write to the select-low-high, select-high-low address is a programmed reset.
// - Programmed reset drives terminal-ready high at once.
// - Programmed reset disables rx/tx interrupts; pending non-modem interrupt stays.
// - Programmed reset drops modem interrupts; modem status then tracks lines silently.
// - Programmed reset clears the overrun flag.
// - Echo mode drives request-to-send low.
// - Command bit 0 low disables every interrupt, modem ones included.
// - Disable lets the receiver finish its character and transmitter drain fully.
// - Odd parity makes total ones odd; received parity bit is never stored.
// - Transmitter and receiver run concurrently.
// - A short low glitch on the receive line never starts reception.
// - Carrier and set-ready changes interrupt at once but never touch transmission.
// - Control bits 0-3 pick the divisor; code 0 means 16x external clock.
// - Codes 1-15 divide the oscillator by the fixed divisor table.
// - Pending modem interrupt freezes modem status until serviced, then rechecks.
// - Unread receive data keeps old word, drops the new one, sets overrun.
`ifndef ACA_PARAMS_SVH
`define ACA_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define ACA_OFS_DATA 8'h00
`define ACA_OFS_STAT 8'h04
`define ACA_OFS_CMD 8'h08
`define ACA_OFS_CTL 8'h0c

// ==========================================================
// Field positions
`define ACA_ST_PE 0
`define ACA_ST_FE 1
`define ACA_ST_OVR 2
`define ACA_ST_RXF 3
`define ACA_ST_TXE 4
`define ACA_ST_DCD 5
`define ACA_ST_DSR 6
`define ACA_ST_IRQ 7
`define ACA_CMD_EN 0
`define ACA_CMD_RXIRQ_OFF 1
`define ACA_CMD_ECHO 4
`define ACA_CMD_PAR_EN 5
`define ACA_CTL_STOP2 7

// ==========================================================
// Reset values and timing
`define ACA_CMD_RST 8'h00
`define ACA_CTL_RST 8'h00
`define ACA_PRG_RST_MASK 8'he0
`define ACA_TX_IRQ_MODE 2'b01
`define ACA_TX_BREAK_MODE 2'b11
`define ACA_TICKS_LAST 4'hf
`define ACA_START_MID 4'h7

// Oscillator edges per 16x tick (divisor / 16) for codes 1..15
`define ACA_DIV_01 12'd2304
`define ACA_DIV_02 12'd1536
`define ACA_DIV_03 12'd1048
`define ACA_DIV_04 12'd856
`define ACA_DIV_05 12'd768
`define ACA_DIV_06 12'd384
`define ACA_DIV_07 12'd192
`define ACA_DIV_08 12'd96
`define ACA_DIV_09 12'd64
`define ACA_DIV_10 12'd48
`define ACA_DIV_11 12'd32
`define ACA_DIV_12 12'd24
`define ACA_DIV_13 12'd16
`define ACA_DIV_14 12'd12
`define ACA_DIV_15 12'd6

`endif

// ==== aca_pkg.sv ====
package aca_pkg;

  // ==========================================================
  // Bus and pin carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } aca_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aca_apb_rsp_t;

  typedef struct packed {
    logic rxd;
    logic cts_n;
    logic dcd_n;
    logic dsr_n;
  } aca_modem_in_t;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
  } aca_modem_out_t;

  // ==========================================================
  // Engine states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} aca_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} aca_rx_st_t;

endpackage

// ==== aca_baud_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aca_params.svh"

module aca_baud_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic osc_rise,
  input wire logic [3:0] baud_code,
  output logic tick16
);

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } aca_baud_st_t;

  aca_baud_st_t r;
  aca_baud_st_t n;
  logic [11:0] div_last;

  // ==========================================================
  // Divisor table, as oscillator edges per 16x tick
  always_comb begin
    unique case (baud_code)
      4'h1: div_last = `ACA_DIV_01 - 12'd1;
      4'h2: div_last = `ACA_DIV_02 - 12'd1;
      4'h3: div_last = `ACA_DIV_03 - 12'd1;
      4'h4: div_last = `ACA_DIV_04 - 12'd1;
      4'h5: div_last = `ACA_DIV_05 - 12'd1;
      4'h6: div_last = `ACA_DIV_06 - 12'd1;
      4'h7: div_last = `ACA_DIV_07 - 12'd1;
      4'h8: div_last = `ACA_DIV_08 - 12'd1;
      4'h9: div_last = `ACA_DIV_09 - 12'd1;
      4'ha: div_last = `ACA_DIV_10 - 12'd1;
      4'hb: div_last = `ACA_DIV_11 - 12'd1;
      4'hc: div_last = `ACA_DIV_12 - 12'd1;
      4'hd: div_last = `ACA_DIV_13 - 12'd1;
      4'he: div_last = `ACA_DIV_14 - 12'd1;
      4'hf: div_last = `ACA_DIV_15 - 12'd1;
      4'h0: div_last = 12'h000;
    endcase
  end

  // ==========================================================
  // Counter: code 0 passes every oscillator edge as a tick
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (osc_rise) begin
      if (r.cnt >= div_last) begin // Ge, so a switch to a smaller divisor mid-count cannot overshoot
        n.cnt = 12'h000;
        n.tick = 1'b1;
      end else begin
        n.cnt = r.cnt + 12'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick16 = r.tick;

endmodule
`default_nettype wire

// ==== aca_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aca_params.svh"

module aca_ctrl
  import aca_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire aca_apb_req_t apb_i,
  output aca_apb_rsp_t apb_o,
  input wire aca_modem_in_t mdm_i,
  input wire logic osc_in,
  output logic osc_out,
  output aca_modem_out_t mdm_o,
  output logic irq_n
);

  // ==========================================================
  // State
  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic cts_s1;
    logic cts_s2;
    logic dcd_s1;
    logic dcd_s2;
    logic dsr_s1;
    logic dsr_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [7:0] cmd;
    logic [7:0] ctl;
    logic [7:0] thr;
    logic thr_full;
    logic [7:0] tsr;
    aca_tx_st_t tx_st;
    logic [3:0] tx_sub;
    logic [2:0] tx_cnt;
    logic tx_par;
    logic [7:0] rbr;
    logic rx_full;
    logic pe;
    logic fe;
    logic ovr;
    logic [7:0] rsr;
    aca_rx_st_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_cnt;
    logic rx_par_err;
    logic rx_armed;
    logic echo_bit;
    logic dcd_lat;
    logic dsr_lat;
    logic irq_dev;
    logic irq_mdm;
    logic txd;
    logic rts_n;
    logic dtr_n;
    logic irq_n;
    logic osc_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aca_state_t;

  aca_state_t r;
  aca_state_t n;

  logic tick16;
  logic en;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic [2:0] last_bit;
  logic [7:0] data_mask;
  logic [7:0] rx_word;
  logic tx_empty_rep;
  logic [7:0] status;
  logic mapped;
  logic [31:0] rd_mux;

  // ==========================================================
  // Baud divider on the synchronised oscillator edge
  aca_baud_gen u_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .osc_rise(r.osc_s2 & ~r.osc_s3),
    .baud_code(r.ctl[3:0]),
    .tick16(tick16)
  );

  // Parity bit for a masked word under the selected mode
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
    logic p;
    p = 1'b0;
    unique case (mode)
      2'b00: p = ~(^d);
      2'b01: p = ^d;
      2'b10: p = 1'b1;
      2'b11: p = 1'b0;
    endcase
    return p;
  endfunction

  // ==========================================================
  // Decodes and helpers
  assign en = r.cmd[`ACA_CMD_EN];
  assign acc_done = apb_i.psel & apb_i.penable & r.pready;
  assign wr_done = acc_done & apb_i.pwrite;
  assign rd_done = acc_done & ~apb_i.pwrite;
  assign last_bit = 3'd7 - {1'b0, r.ctl[6:5]};
  assign data_mask = 8'hff >> r.ctl[6:5];
  assign rx_word = r.rsr >> r.ctl[6:5]; // Short words arrive high-aligned
  // Empty is hidden while clear-to-send is false, so software can infer it
  assign tx_empty_rep = ~r.thr_full & ~r.cts_s2;
  assign mapped = (apb_i.paddr == `ACA_OFS_DATA) || (apb_i.paddr == `ACA_OFS_STAT) ||
                  (apb_i.paddr == `ACA_OFS_CMD) || (apb_i.paddr == `ACA_OFS_CTL);

  // Status word layout
  always_comb begin
    status = 8'h00;
    status[`ACA_ST_PE] = r.pe;
    status[`ACA_ST_FE] = r.fe;
    status[`ACA_ST_OVR] = r.ovr;
    status[`ACA_ST_RXF] = r.rx_full;
    status[`ACA_ST_TXE] = tx_empty_rep;
    status[`ACA_ST_DCD] = r.dcd_lat;
    status[`ACA_ST_DSR] = r.dsr_lat;
    status[`ACA_ST_IRQ] = r.irq_dev | r.irq_mdm;
  end

  // Read data selection, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (apb_i.paddr == `ACA_OFS_DATA) begin
      rd_mux = {24'h000000, r.rbr};
    end else if (apb_i.paddr == `ACA_OFS_STAT) begin
      rd_mux = {24'h000000, status};
    end else if (apb_i.paddr == `ACA_OFS_CMD) begin
      rd_mux = {24'h000000, r.cmd};
    end else if (apb_i.paddr == `ACA_OFS_CTL) begin
      rd_mux = {24'h000000, r.ctl};
    end
  end

  // ==========================================================
  // Next state: bus effects first, engine events after, so a set wins
  always_comb begin
    n = r;
    // Pin synchronisers
    n.rx_s1 = mdm_i.rxd;
    n.rx_s2 = r.rx_s1;
    n.cts_s1 = mdm_i.cts_n;
    n.cts_s2 = r.cts_s1;
    n.dcd_s1 = mdm_i.dcd_n;
    n.dcd_s2 = r.dcd_s1;
    n.dsr_s1 = mdm_i.dsr_n;
    n.dsr_s2 = r.dsr_s1;
    n.osc_s1 = osc_in;
    n.osc_s2 = r.osc_s1;
    n.osc_s3 = r.osc_s2;
    n.osc_out = ~r.osc_s2;

    // APB: one wait state, answer registered
    n.pready = 1'b0;
    if (apb_i.psel && apb_i.penable && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = ~mapped;
      n.prdata = rd_mux;
    end

    if (wr_done) begin
      if (apb_i.paddr == `ACA_OFS_DATA) begin
        n.thr = apb_i.pwdata[7:0];
        n.thr_full = 1'b1;
      end else if (apb_i.paddr == `ACA_OFS_STAT) begin
        // Programmed reset: only low command bits, overrun and modem pending
        n.cmd = r.cmd & `ACA_PRG_RST_MASK;
        n.ovr = 1'b0;
        n.irq_mdm = 1'b0;
      end else if (apb_i.paddr == `ACA_OFS_CMD) begin
        n.cmd = apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `ACA_OFS_CTL) begin
        n.ctl = apb_i.pwdata[7:0];
      end
    end

    if (rd_done) begin
      if (apb_i.paddr == `ACA_OFS_STAT) begin
        n.irq_dev = 1'b0;
        n.irq_mdm = 1'b0;
      end else if (apb_i.paddr == `ACA_OFS_DATA) begin
        n.rx_full = 1'b0;
      end
    end

    // Modem lines: frozen while their interrupt waits; the recheck
    // after a servicing read happens the cycle after the clear
    if (!r.irq_mdm && (r.dcd_s2 != r.dcd_lat || r.dsr_s2 != r.dsr_lat)) begin
      n.dcd_lat = r.dcd_s2;
      n.dsr_lat = r.dsr_s2;
      if (n.cmd[`ACA_CMD_EN]) begin
        n.irq_mdm = 1'b1;
      end
    end

    // Transmitter, independent of the receiver; of the modem lines only clear-to-send stalls it
    if (tick16) begin
      unique case (r.tx_st)
        TX_IDLE: begin
          // Holding data drains even after disable
          if (r.thr_full && !r.cts_s2) begin
            n.tsr = r.thr & data_mask;
            n.tx_par = par_bit(r.thr & data_mask, r.cmd[7:6]);
            n.thr_full = wr_done && apb_i.paddr == `ACA_OFS_DATA;
            n.tx_st = TX_START;
            n.tx_sub = 4'h0;
            if (en && r.cmd[3:2] == `ACA_TX_IRQ_MODE) begin
              n.irq_dev = 1'b1;
            end
          end
        end
        TX_START: begin
          n.tx_sub = r.tx_sub + 4'h1;
          if (r.tx_sub == `ACA_TICKS_LAST) begin
            n.tx_st = TX_DATA;
            n.tx_cnt = 3'd0;
          end
        end
        TX_DATA: begin
          n.tx_sub = r.tx_sub + 4'h1;
          if (r.tx_sub == `ACA_TICKS_LAST) begin
            n.tsr = r.tsr >> 1;
            n.tx_cnt = r.tx_cnt + 3'd1;
            if (r.tx_cnt == last_bit) begin
              n.tx_cnt = 3'd0;
              n.tx_st = r.cmd[`ACA_CMD_PAR_EN] ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          n.tx_sub = r.tx_sub + 4'h1;
          if (r.tx_sub == `ACA_TICKS_LAST) begin
            n.tx_st = TX_STOP;
          end
        end
        TX_STOP: begin
          n.tx_sub = r.tx_sub + 4'h1;
          if (r.tx_sub == `ACA_TICKS_LAST) begin
            if (r.ctl[`ACA_CTL_STOP2] && r.tx_cnt == 3'd0) begin
              n.tx_cnt = 3'd1;
            end else begin
              n.tx_st = TX_IDLE;
            end
          end
        end
      endcase
    end

    // Receiver: needs a mark before a start, and a start held to mid-bit
    if (tick16) begin
      unique case (r.rx_st)
        RX_IDLE: begin
          n.echo_bit = 1'b1;
          if (r.rx_s2) begin
            n.rx_armed = 1'b1;
          end else if (r.rx_armed && en) begin
            n.rx_armed = 1'b0;
            n.rx_st = RX_START;
            n.rx_sub = 4'h0;
          end
        end
        RX_START: begin
          n.rx_sub = r.rx_sub + 4'h1;
          if (r.rx_sub == `ACA_START_MID) begin
            if (r.rx_s2) begin
              n.rx_st = RX_IDLE;
            end else begin
              n.rx_st = RX_DATA;
              n.rx_sub = 4'h0;
              n.rx_cnt = 3'd0;
              n.rsr = 8'h00;
              n.rx_par_err = 1'b0;
              n.echo_bit = 1'b0;
            end
          end
        end
        RX_DATA: begin
          n.rx_sub = r.rx_sub + 4'h1;
          if (r.rx_sub == `ACA_TICKS_LAST) begin
            n.rsr = {r.rx_s2, r.rsr[7:1]};
            n.echo_bit = r.rx_s2;
            n.rx_cnt = r.rx_cnt + 3'd1;
            if (r.rx_cnt == last_bit) begin
              n.rx_st = r.cmd[`ACA_CMD_PAR_EN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          n.rx_sub = r.rx_sub + 4'h1;
          if (r.rx_sub == `ACA_TICKS_LAST) begin
            // Parity bit only checked, never kept
            n.rx_par_err = r.rx_s2 != par_bit(rx_word, r.cmd[7:6]);
            n.echo_bit = r.rx_s2;
            n.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          n.rx_sub = r.rx_sub + 4'h1;
          if (r.rx_sub == `ACA_TICKS_LAST) begin
            n.echo_bit = r.rx_s2;
            n.rx_st = RX_IDLE;
            if (r.rx_full && !(rd_done && apb_i.paddr == `ACA_OFS_DATA)) begin
              n.ovr = 1'b1;
            end else begin
              n.rbr = rx_word;
              n.rx_full = 1'b1;
              n.fe = ~r.rx_s2;
              n.pe = r.rx_par_err;
            end
            if (en && !r.cmd[`ACA_CMD_RXIRQ_OFF]) begin
              n.irq_dev = 1'b1;
            end
          end
        end
      endcase
    end

    // Pin outputs from the next register state; the txd echo and break selects use the current command
    n.dtr_n = ~n.cmd[`ACA_CMD_EN];
    n.rts_n = (n.cmd[3:2] == 2'b00) && !n.cmd[`ACA_CMD_ECHO];
    n.irq_n = ~(n.irq_dev | n.irq_mdm);
    if (r.cmd[`ACA_CMD_ECHO]) begin
      n.txd = n.echo_bit; // Echo lags the line by about half a bit
    end else begin
      unique case (n.tx_st)
        TX_IDLE: n.txd = !(r.cmd[3:2] == `ACA_TX_BREAK_MODE);
        TX_START: n.txd = 1'b0;
        TX_DATA: n.txd = n.tsr[0];
        TX_PAR: n.txd = n.tx_par;
        TX_STOP: n.txd = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
      r.cmd <= `ACA_CMD_RST;
      r.ctl <= `ACA_CTL_RST;
      r.txd <= 1'b1;
      r.rts_n <= 1'b1;
      r.dtr_n <= 1'b1;
      r.irq_n <= 1'b1;
      r.echo_bit <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign apb_o.prdata = r.prdata;
  assign apb_o.pready = r.pready;
  assign apb_o.pslverr = r.pslverr;
  assign mdm_o.txd = r.txd;
  assign mdm_o.rts_n = r.rts_n;
  assign mdm_o.dtr_n = r.dtr_n;
  assign irq_n = r.irq_n;
  assign osc_out = r.osc_out;

endmodule
`default_nettype wire

// ==== aca_ctrl_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aca_params.svh"

module aca_ctrl_monitor
  import aca_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire aca_apb_req_t apb_i,
  input wire aca_apb_rsp_t apb_o,
  input wire aca_modem_in_t mdm_i,
  input wire logic osc_in,
  input wire logic osc_out,
  input wire aca_modem_out_t mdm_o,
  input wire logic irq_n
);
  // ==========
  // Bus events
  wire done = apb_i.psel && apb_i.penable && apb_o.pready;
  wire wr_done = done && apb_i.pwrite;
  wire stat_rd = done && !apb_i.pwrite && apb_i.paddr == `ACA_OFS_STAT;
  wire prg_rst = wr_done && apb_i.paddr == `ACA_OFS_STAT;
  logic [7:0] cmd_r;

  // Command shadow, so the checks need no view of the internals
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_r <= `ACA_CMD_RST;
    end else if (wr_done && apb_i.paddr == `ACA_OFS_CMD) begin
      cmd_r <= apb_i.pwdata[7:0];
    end else if (prg_rst) begin
      cmd_r <= cmd_r & `ACA_PRG_RST_MASK;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ==========
  // Bus timing
  AST_APB_ONE_WAIT: assert property (apb_i.psel && !apb_i.penable ##1 apb_i.psel && apb_i.penable |=> apb_o.pready)
    else $error("pready missing in second access cycle");
  AST_APB_PULSE: assert property (apb_o.pready |=> !apb_o.pready)
    else $error("pready held longer than one cycle");
  AST_APB_UNMAPPED: assert property (done && !(apb_i.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})
    |-> apb_o.pslverr && apb_o.prdata == 32'h0)
    else $error("unmapped access not refused");

  // ==========
  // Interrupt and modem pins; a stale pin here means a lost event
  AST_IRQ_CLEAR: assert property (stat_rd && !irq_n |-> ##[1:3] irq_n)
    else $error("status read left irq asserted");
  AST_MODEM_IRQ: assert property (cmd_r[0] && $past(cmd_r[0]) && irq_n && $changed(mdm_i.dcd_n) |-> ##[1:8] !irq_n)
    else $error("carrier change raised no interrupt");
  AST_IRQ_OFF: assert property (!cmd_r[0] && $past(!cmd_r[0]) && $past(!cmd_r[0], 2) && irq_n |=> irq_n)
    else $error("interrupt raised while disabled");
  AST_DTR_PRG: assert property (prg_rst |-> ##[1:2] mdm_o.dtr_n)
    else $error("terminal ready not released by programmed reset");
  AST_DTR_EN: assert property (cmd_r[0] && $past(cmd_r[0]) |-> !mdm_o.dtr_n)
    else $error("terminal ready not driven while enabled");
  AST_ECHO_RTS: assert property (cmd_r[`ACA_CMD_ECHO] && $past(cmd_r[`ACA_CMD_ECHO]) |-> !mdm_o.rts_n)
    else $error("request to send high in echo mode");

  COV_STAT_IRQ: cover property (stat_rd && !irq_n);
  COV_PRG_RST: cover property (prg_rst);
  COV_TX_START: cover property ($fell(mdm_o.txd));
endmodule

bind aca_ctrl aca_ctrl_monitor mon (.sys_clk(sys_clk), .resetn(resetn), .apb_i(apb_i), .apb_o(apb_o),
  .mdm_i(mdm_i), .osc_in(osc_in), .osc_out(osc_out), .mdm_o(mdm_o), .irq_n(irq_n));

`default_nettype wire

// ==== aca_modem_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module aca_modem_model
  import aca_pkg::*;
(
  input wire logic osc_in,
  input wire aca_modem_out_t mdm_o,
  output var aca_modem_in_t mdm_i
);
  // ==========
  // Line state; a bit lasts bit_len oscillator edges
  int bit_len = 16;
  logic [8:0] got = '0;
  initial mdm_i = 4'b1000;

  // Frame out: start, n bits LSB first, then a long idle high
  task automatic send(input logic [8:0] d, input int n);
    @(posedge osc_in);
    mdm_i.rxd <= 1'b0;
    repeat (bit_len) @(posedge osc_in);
    for (int i = 0; i < n; i++) begin
      mdm_i.rxd <= d[i];
      repeat (bit_len) @(posedge osc_in);
    end
    mdm_i.rxd <= 1'b1;
    repeat (2 * bit_len) @(posedge osc_in);
  endtask

  // Short low pulse, too brief to be a start bit
  task automatic glitch(input int n);
    @(posedge osc_in);
    mdm_i.rxd <= 1'b0;
    repeat (n) @(posedge osc_in);
    mdm_i.rxd <= 1'b1;
  endtask

  // Sample the adapter's frame at bit centres
  task automatic grab(input int n);
    @(negedge mdm_o.txd);
    repeat (bit_len / 2) @(posedge osc_in);
    for (int i = 0; i < n; i++) begin
      repeat (bit_len) @(posedge osc_in);
      got[i] = mdm_o.txd;
    end
  endtask

  // Clear-to-send level; high stalls the transmitter and hides tx empty
  task automatic cts(input logic v);
    mdm_i.cts_n <= v;
  endtask

  // Carrier and set-ready levels
  task automatic lines(input logic dcd, input logic dsr);
    mdm_i.dcd_n <= dcd;
    mdm_i.dsr_n <= dsr;
  endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aca_params.svh"

module tb_top
  import aca_pkg::*;
;
  // ==========
  // Clocks, pins and counters
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic osc_in = 1'b0;
  aca_apb_req_t apb_i = '0;
  aca_apb_rsp_t apb_o;
  aca_modem_in_t mdm_i;
  aca_modem_out_t mdm_o;
  logic osc_out;
  logic irq_n;
  logic err;
  logic [31:0] rd;
  time t0;
  int miscompares = 0;
  int checked = 0;
  logic [3:0] codes [3] = '{4'h0, 4'he, 4'hf};
  int divs [3] = '{16, 192, 96};

  always #5 sys_clk = ~sys_clk;
  // Oscillator kept well under a quarter of the system clock
  always #30 osc_in = ~osc_in;

  aca_ctrl DUT (.sys_clk(sys_clk), .resetn(resetn), .apb_i(apb_i), .apb_o(apb_o), .mdm_i(mdm_i),
    .osc_in(osc_in), .osc_out(osc_out), .mdm_o(mdm_o), .irq_n(irq_n));
  aca_modem_model modem (.osc_in(osc_in), .mdm_o(mdm_o), .mdm_i(mdm_i));

  // ==========
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; waits for pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
    @(posedge sys_clk);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 50);
    if (apb_o.pready !== 1'b1) begin
      miscompares++; // A lost answer counts as a mismatch
    end
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    apb(1'b0, a, 8'h00);
    check(w, rd, {24'h0, e});
  endtask

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the slowest baud rates dominate, about 0.3 ms in all
  initial begin
    #1000000;
    miscompares++;
    results();
  end

  // ==========
  // Test sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    check("modem out", mdm_o, 3'b111);
    rdc(`ACA_OFS_STAT, 8'h10, "status");
    rdc(`ACA_OFS_CMD, 8'h00, "cmd");
    rdc(`ACA_OFS_CTL, 8'h00, "ctl");
    apb(1'b0, 8'h10, 8'h00);
    check("slverr", err, 1);
    check("unmapped rd", rd, 0);
    // Both directions at once
    wr(`ACA_OFS_CMD, 8'h01);
    fork
      modem.grab(8);
      begin wr(`ACA_OFS_DATA, 8'ha5); modem.send(9'h03c, 8); end
    join
    check("tx word", modem.got[7:0], 8'ha5);
    check("irq_n", irq_n, 0);
    rdc(`ACA_OFS_STAT, 8'h98, "status");
    repeat (3) @(posedge sys_clk);
    check("irq_n", irq_n, 1);
    rdc(`ACA_OFS_DATA, 8'h3c, "rx data");
    // Overrun, then overrun cleared by programmed reset
    modem.send(9'h011, 8);
    modem.send(9'h022, 8);
    rdc(`ACA_OFS_STAT, 8'h9c, "status");
    rdc(`ACA_OFS_DATA, 8'h11, "rx data");
    modem.send(9'h033, 8);
    modem.send(9'h044, 8);
    wr(`ACA_OFS_STAT, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("dtr_n", mdm_o.dtr_n, 1);
    check("irq_n", irq_n, 0);
    rdc(`ACA_OFS_STAT, 8'h98, "status");
    rdc(`ACA_OFS_CMD, 8'h00, "cmd");
    rdc(`ACA_OFS_DATA, 8'h33, "rx data");
    // Odd parity both ways, bad then good
    wr(`ACA_OFS_CMD, 8'h21);
    fork
      modem.grab(9);
      begin wr(`ACA_OFS_DATA, 8'h03); modem.send(9'h107, 9); end
    join
    check("tx parity", modem.got, 9'h103);
    rdc(`ACA_OFS_STAT, 8'h99, "status");
    rdc(`ACA_OFS_DATA, 8'h07, "rx data");
    modem.send(9'h007, 9);
    rdc(`ACA_OFS_STAT, 8'h98, "status");
    rdc(`ACA_OFS_DATA, 8'h07, "rx data");
    // Short low pulse on the receive line
    modem.glitch(3);
    repeat (320) @(posedge osc_in);
    rdc(`ACA_OFS_STAT, 8'h10, "status");
    // Carrier change during a frame
    fork
      modem.grab(9);
      begin wr(`ACA_OFS_DATA, 8'h5a); repeat (40) @(posedge osc_in); modem.lines(1'b1, 1'b0); end
    join
    check("tx word", modem.got, 9'h15a);
    check("irq_n", irq_n, 0);
    rdc(`ACA_OFS_STAT, 8'hb0, "status");
    modem.lines(1'b1, 1'b1);
    repeat (10) @(posedge sys_clk);
    check("irq_n", irq_n, 0);
    wr(`ACA_OFS_STAT, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("irq_n", irq_n, 1);
    modem.lines(1'b0, 1'b1);
    repeat (10) @(posedge sys_clk);
    check("irq_n", irq_n, 1);
    rdc(`ACA_OFS_STAT, 8'h50, "status");
    // Clear-to-send false: empty hidden, host must infer it
    modem.cts(1'b1);
    repeat (5) @(posedge sys_clk);
    rdc(`ACA_OFS_STAT, 8'h40, "status");
    modem.cts(1'b0);
    repeat (5) @(posedge sys_clk);
    // Echo, then disable right after the data write
    wr(`ACA_OFS_CMD, 8'h11);
    repeat (3) @(posedge sys_clk);
    check("rts_n", mdm_o.rts_n, 0);
    wr(`ACA_OFS_CMD, 8'h01);
    fork
      modem.grab(8);
      begin wr(`ACA_OFS_DATA, 8'hc3); wr(`ACA_OFS_CMD, 8'h00); end
    join
    check("tx word", modem.got[7:0], 8'hc3);
    // Start bit length for divisor codes 0, e and f
    wr(`ACA_OFS_CMD, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(`ACA_OFS_CTL, {4'h0, codes[i]});
      fork
        begin @(negedge mdm_o.txd); t0 = $time; @(posedge mdm_o.txd); end
        wr(`ACA_OFS_DATA, 8'h01);
      join
      check("bit time", 32'(($time - t0) / 60), divs[i]);
      repeat (10 * divs[i]) @(posedge osc_in);
    end
    results();
  end
endmodule

`default_nettype wire
